// [rtl/qwr_defs.svh]
`ifndef QWR_DEFS_SVH
`define QWR_DEFS_SVH

// ****************************************
// Link opcodes and field figures
// ****************************************
`define QWR_OP_DUAL_IO 8'hBB
`define QWR_OP_QUAD_IO 8'hEB
`define QWR_OP_WORD_QUAD 8'hE7
`define QWR_OP_OCTAL_QUAD 8'hE3
`define QWR_OP_SET_WRAP 8'h77
`define QWR_DUMMY_QUAD_IO 3'h4
`define QWR_DUMMY_WORD_QUAD 3'h2
`define QWR_FIELD_BITS 6'h20
`define QWR_REPEAT_CODE 2'b10
`define QWR_CRB_RESET 8'h10
`define QWR_WRAP_RESET 3'h1
`define QWR_WRAP_BASE 8'h08
`define QWR_SCLK_HALF 4

// ****************************************
// Controller register map
// ****************************************
`define QWR_REG_CTRL 32'h0000_0000
`define QWR_REG_TXWORD 32'h0000_0004
`define QWR_REG_STATUS 32'h0000_0008
`define QWR_REG_RXDATA 32'h0000_000C
`define QWR_CTRL_SEND_OP 8
`define QWR_CTRL_DUAL 9
`define QWR_CTRL_DUMMY_LSB 12
`define QWR_CTRL_COUNT_LSB 16
`define QWR_CTRL_START 31

`endif

// [rtl/qwr_pkg.sv]
package qwr_pkg;

    typedef enum logic [5:0] {
        FL_IDLE = 6'h01,
        FL_OPCODE = 6'h02,
        FL_FIELD = 6'h04,
        FL_DUMMY = 6'h08,
        FL_DATA = 6'h10,
        FL_IGNORE = 6'h20
    } qwr_flash_state_e;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_OPCODE = 5'h02,
        HS_FIELD = 5'h04,
        HS_DUMMY = 5'h08,
        HS_RX = 5'h10
    } qwr_host_state_e;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic cs_meta;
        logic cs_sync;
        logic [3:0] io_meta;
        logic [3:0] io_sync;
        qwr_flash_state_e state;
        logic [7:0] opcode;
        logic [31:0] field;
        logic [5:0] bits;
        logic ones_ok;
        logic [2:0] dummy_left;
        logic [23:0] addr;
        logic [7:0] out_byte;
        logic [3:0] out_bits;
        logic [7:0] continuous_read_bits;
        logic [7:0] repeat_op;
        logic [2:0] wrap_setting;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } qwr_flash_s;

    typedef struct packed {
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        qwr_host_state_e phase;
        logic [5:0] rem;
        logic [7:0] op;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [7:0] opcode;
        logic send_op;
        logic dual;
        logic [2:0] dummy;
        logic [2:0] count;
        logic [31:0] txword;
        logic [3:0] io_meta;
        logic [3:0] io_sync;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic ap_valid;
        logic ap_write;
        logic [31:0] ap_addr;
        logic rd_wait;
        logic [31:0] hrdata;
    } qwr_host_s;

endpackage

// [rtl/qwr_if.sv]
interface qwr_if;
    logic sclk;
    logic cs_n;
    logic [3:0] io_host_out;
    logic [3:0] io_host_oe;
    logic [3:0] io_flash_out;
    logic [3:0] io_flash_oe;
    logic [3:0] io;

    // Undriven lines float high as with a pull-up
    assign io = (io_host_oe & io_host_out) | (~io_host_oe & io_flash_oe & io_flash_out)
        | ~(io_host_oe | io_flash_oe);

    modport host (output sclk, cs_n, io_host_out, io_host_oe, input io);
    modport flash (input sclk, cs_n, io, output io_flash_out, io_flash_oe);
endinterface

// [rtl/qwr_flash.sv]
// Register access over AHB-Lite and the register offsets were decided locally.
`include "qwr_defs.svh"
// Behaviour
// - Word quad read: even address, two dummies
// - Word quad read needs quad enable
// - Octal word read needs quad enable
// - Octal word read: aligned address, no dummies
// - Eight mode bits follow 24-bit address
// - Mode bits 5:4 = 10 skips next opcode
// - Other mode values restore opcode decoding
// - Remaining mode bits are ignored
// - Repeat applies to four I/O reads
// - Host releases lines before first output
// - Wrap set: opcode, 24 dummies, wrap byte
// - Wrap bits 7 and 3:0 ignored
// - Wrap length bits pick 8 to 64
// - Wrap disable bit resets high, linear
// - Wrapped output loops inside aligned section
// - Wrap setting persists for quad reads
// - Host rewrites wrap after system reset
// - Mode reset forces bit four high
// - Quad mode reset: eight clocks all-ones
// - Dual mode reset: sixteen clocks all-ones
// - Host sends mode reset after reset
// - Fast quad read: four lines, four dummies
module qwr_flash
    import qwr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    qwr_if.flash link,
    input wire logic quad_io_enable_in,
    output logic execute_in_place_out,
    output logic [2:0] wrap_setting_out
);

    qwr_flash_s q;
    qwr_flash_s d;
    logic rise;
    logic fall;
    logic dual;
    logic wrap_on;
    logic [7:0] op_v;
    logic [31:0] field_v;
    logic [5:0] bits_v;
    logic [7:0] byte_v;
    logic [23:0] mask_v;
    logic [23:0] addr_inc;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        rise = q.sclk_sync[1] & ~q.sclk_sync[2];
        fall = ~q.sclk_sync[1] & q.sclk_sync[2];
        dual = (q.opcode == `QWR_OP_DUAL_IO);
        op_v = {q.opcode[6:0], q.io_sync[0]};
        field_v = dual ? {q.field[29:0], q.io_sync[1:0]} : {q.field[27:0], q.io_sync};
        bits_v = q.bits + (dual ? 6'h02 : 6'h04);
        byte_v = (q.out_bits == 4'h0) ? q.addr[7:0] : q.out_byte;
        mask_v = {16'h0000, (`QWR_WRAP_BASE << q.wrap_setting[2:1]) - 8'h01};
        // Only the fast quad and word quad reads wrap
        wrap_on = ~q.wrap_setting[0] && (q.opcode == `QWR_OP_QUAD_IO
            || q.opcode == `QWR_OP_WORD_QUAD);
        addr_inc = q.addr + 24'h00_0001;
        // Pins pass two flops; sclk gets a third to find edges
        d.sclk_sync = {q.sclk_sync[1:0], link.sclk};
        d.cs_meta = link.cs_n;
        d.cs_sync = q.cs_meta;
        d.io_meta = link.io;
        d.io_sync = q.io_meta;
        // Lines drop at once when the data phase ends
        d.io_oe = (q.state == FL_DATA) ? q.io_oe : 4'h0;
        if (q.cs_sync) begin
            d.state = FL_IDLE;
            d.io_oe = 4'h0;
        end else begin
            case (q.state)
                FL_IDLE: begin
                    d.bits = 6'h00;
                    d.out_bits = 4'h0;
                    d.ones_ok = 1'b1;
                    // Armed repeat: address follows select directly
                    if (q.continuous_read_bits[5:4] == `QWR_REPEAT_CODE) begin
                        d.opcode = q.repeat_op;
                        d.state = FL_FIELD;
                    end else begin
                        d.opcode = 8'h00;
                        d.state = FL_OPCODE;
                    end
                end
                FL_OPCODE: begin
                    // Opcode on line zero, most significant bit first
                    if (rise) begin
                        d.opcode = op_v;
                        d.bits = q.bits + 6'h01;
                        if (q.bits == 6'h07) begin
                            d.bits = 6'h00;
                            case (op_v)
                                `QWR_OP_DUAL_IO, `QWR_OP_SET_WRAP: begin
                                    d.state = FL_FIELD;
                                end
                                `QWR_OP_QUAD_IO, `QWR_OP_WORD_QUAD, `QWR_OP_OCTAL_QUAD: begin
                                    d.state = quad_io_enable_in ? FL_FIELD : FL_IGNORE;
                                end
                                default: begin
                                    d.state = FL_IGNORE;
                                end
                            endcase
                        end
                    end
                end
                FL_FIELD: begin
                    if (rise) begin
                        d.field = field_v;
                        d.bits = bits_v;
                        d.ones_ok = q.ones_ok & q.io_sync[0];
                        if (bits_v == `QWR_FIELD_BITS) begin
                            if (q.opcode == `QWR_OP_SET_WRAP) begin
                                // Only bits 6:4 are stored, the rest are dropped
                                d.wrap_setting = field_v[6:4];
                                d.state = FL_IGNORE;
                            end else begin
                                d.addr = field_v[31:8];
                                d.continuous_read_bits = field_v[7:0];
                                d.repeat_op = q.opcode;
                                // Line zero high on every field clock is the mode reset
                                if (q.ones_ok & q.io_sync[0]) begin
                                    d.continuous_read_bits[4] = 1'b1;
                                end
                                if (q.opcode == `QWR_OP_QUAD_IO) begin
                                    d.dummy_left = `QWR_DUMMY_QUAD_IO;
                                    d.state = FL_DUMMY;
                                end else if (q.opcode == `QWR_OP_WORD_QUAD) begin
                                    d.dummy_left = `QWR_DUMMY_WORD_QUAD;
                                    d.state = FL_DUMMY;
                                end else begin
                                    // No alignment check: low address bits are the host's duty
                                    d.state = FL_DATA;
                                end
                            end
                        end
                    end
                end
                FL_DUMMY: begin
                    // Lines stay released while the host turns around
                    if (rise) begin
                        d.dummy_left = q.dummy_left - 3'h1;
                        if (q.dummy_left == 3'h1) begin
                            d.state = FL_DATA;
                        end
                    end
                end
                FL_DATA: begin
                    // Drive on the falling edge; host samples on the next falling edge
                    if (fall) begin
                        d.io_oe = dual ? 4'h3 : 4'hF;
                        d.io_out = dual ? {2'b00, byte_v[7:6]} : byte_v[7:4];
                        d.out_byte = dual ? (byte_v << 2) : (byte_v << 4);
                        d.out_bits = q.out_bits + (dual ? 4'h2 : 4'h4);
                        // Whole byte out: step the address
                        if (d.out_bits == 4'h8) begin
                            d.out_bits = 4'h0;
                            d.addr = wrap_on ? ((q.addr & ~mask_v) | (addr_inc & mask_v))
                                : addr_inc;
                        end
                    end
                end
                FL_IGNORE: begin
                    // Refused or finished frame: wait for select to rise
                    d.state = FL_IGNORE;
                end
                default: begin
                    d.state = FL_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Mode and wrap bits start at their power-on values
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '{
                sclk_sync: 3'h0,
                cs_meta: 1'b1,
                cs_sync: 1'b1,
                state: FL_IDLE,
                continuous_read_bits: `QWR_CRB_RESET,
                wrap_setting: `QWR_WRAP_RESET,
                default: '0
            };
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.io_flash_out = q.io_out;
    assign link.io_flash_oe = q.io_oe;
    // Repeat armed while mode bits 5:4 hold 10
    assign execute_in_place_out = (q.continuous_read_bits[5:4] == `QWR_REPEAT_CODE);
    assign wrap_setting_out = q.wrap_setting;

endmodule // qwr_flash

// [rtl/qwr_host.sv]
`include "qwr_defs.svh"
module qwr_host
    import qwr_pkg::*;
#(
    parameter logic [7:0] SCLK_HALF = `QWR_SCLK_HALF
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    qwr_if.host link,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out
);

    qwr_host_s q;
    qwr_host_s d;
    logic tick;
    logic busy;
    logic [5:0] field_clks;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        busy = (q.phase != HS_IDLE);
        tick = (q.div == SCLK_HALF - 8'h01);
        d.div = (!busy || tick) ? 8'h00 : q.div + 8'h01;
        d.io_meta = link.io;
        d.io_sync = q.io_meta;
        field_clks = q.dual ? 6'h10 : 6'h08;
        // Bus: reads get one wait state so data is fresh
        if (hready_in) begin
            d.ap_valid = hsel_in & htrans_in[1];
            d.ap_write = hwrite_in;
            d.ap_addr = haddr_in;
            d.rd_wait = hsel_in & htrans_in[1] & ~hwrite_in;
        end
        if (q.rd_wait) begin
            d.rd_wait = 1'b0;
            case (q.ap_addr)
                `QWR_REG_CTRL: d.hrdata = {13'h0000, q.count, 1'b0, q.dummy, 2'b00,
                    q.dual, q.send_op, q.opcode};
                `QWR_REG_TXWORD: d.hrdata = q.txword;
                `QWR_REG_STATUS: d.hrdata = {31'h0000_0000, busy};
                `QWR_REG_RXDATA: d.hrdata = q.rx;
                default: d.hrdata = 32'h0000_0000;
            endcase
        end
        if (busy && tick) begin
            d.sclk = ~q.sclk;
            if (q.sclk) begin
                // Late sample leaves room for both synchronisers
                if (q.phase == HS_RX) begin
                    d.rx = q.dual ? {q.rx[29:0], q.io_sync[1:0]} : {q.rx[27:0], q.io_sync};
                end
                d.rem = q.rem - 6'h01;
                if (q.phase == HS_OPCODE) begin
                    d.op = q.op << 1;
                end
                if (q.phase == HS_FIELD) begin
                    d.tx = q.dual ? (q.tx << 2) : (q.tx << 4);
                end
                if (q.rem == 6'h01) begin
                    if (q.phase == HS_OPCODE) begin
                        d.phase = HS_FIELD;
                        d.rem = field_clks;
                    end else if (q.phase == HS_FIELD && q.dummy != 3'h0) begin
                        d.phase = HS_DUMMY;
                        d.rem = {3'h0, q.dummy};
                    end else if (q.phase != HS_RX && q.count != 3'h0) begin
                        d.phase = HS_RX;
                        d.rem = q.dual ? {1'b0, q.count, 2'b00} : {2'b00, q.count, 1'b0};
                    end else begin
                        d.phase = HS_IDLE;
                        d.cs_n = 1'b1;
                    end
                end
            end
        end
        if (q.ap_valid && q.ap_write && !busy) begin
            if (q.ap_addr == `QWR_REG_TXWORD) begin
                d.txword = hwdata_in;
            end
            if (q.ap_addr == `QWR_REG_CTRL) begin
                d.opcode = hwdata_in[7:0];
                d.send_op = hwdata_in[`QWR_CTRL_SEND_OP];
                d.dual = hwdata_in[`QWR_CTRL_DUAL];
                d.dummy = hwdata_in[`QWR_CTRL_DUMMY_LSB +: 3];
                d.count = hwdata_in[`QWR_CTRL_COUNT_LSB +: 3];
                if (hwdata_in[`QWR_CTRL_START]) begin
                    d.cs_n = 1'b0;
                    d.sclk = 1'b0;
                    d.div = 8'h00;
                    d.op = hwdata_in[7:0];
                    d.tx = q.txword;
                    d.rx = 32'h0000_0000;
                    d.phase = d.send_op ? HS_OPCODE : HS_FIELD;
                    d.rem = d.send_op ? 6'h08 : (d.dual ? 6'h10 : 6'h08);
                end
            end
        end
        case (d.phase)
            HS_OPCODE: begin
                d.io_oe = 4'h1;
                d.io_out = {3'b000, d.op[7]};
            end
            HS_FIELD: begin
                d.io_oe = d.dual ? 4'h3 : 4'hF;
                d.io_out = d.dual ? {2'b00, d.tx[31:30]} : d.tx[31:28];
            end
            default: begin
                d.io_oe = 4'h0;
                d.io_out = 4'h0;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '{cs_n: 1'b1, phase: HS_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.io_host_out = q.io_out;
    assign link.io_host_oe = q.io_oe;
    assign hreadyout_out = ~q.rd_wait;
    assign hresp_out = 1'b0;
    assign hrdata_out = q.hrdata;

endmodule // qwr_host

// [sim/qwr_link_properties.sv]
module qwr_link_properties (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_host_out,
    input wire logic [3:0] io_host_oe,
    input wire logic [3:0] io_flash_out,
    input wire logic [3:0] io_flash_oe,
    input wire logic [3:0] io
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ****************************************
    // Line ownership
    // ****************************************
    a_no_drive_clash:
        assert property ((io_flash_oe != 4'h0) |-> (io_host_oe == 4'h0))
        else $error("host and flash drive the lines together");
    a_host_released_early:
        assert property ($rose(io_flash_oe != 4'h0) |-> ($past(io_host_oe, 2) == 4'h0))
        else $error("host still drove the lines just before read data");
    a_idle_lines_high:
        assert property (cs_n [*5] |-> (io_host_oe == 4'h0 && io == 4'hF))
        else $error("lines not released high outside a frame");
    a_flash_lanes:
        assert property (io_flash_oe inside {4'h0, 4'h3, 4'hF})
        else $error("flash drives an odd set of lines");
    a_host_lanes:
        assert property (io_host_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("host drives an odd set of lines");
    a_data_on_low_clock:
        assert property ((io_flash_oe != 4'h0 && $changed(io_flash_out)) |-> !sclk)
        else $error("read data changed while link clock high");

    // ****************************************
    // Framing
    // ****************************************
    a_clock_idle_low:
        assert property (cs_n |-> !sclk)
        else $error("link clock high outside a frame");
    a_frame_start_quiet:
        assert property ($fell(cs_n) |-> (io_flash_oe == 4'h0) [*8])
        else $error("flash drove lines right after select fell");
    a_flash_idle_quiet:
        assert property (cs_n [*5] |-> (io_flash_oe == 4'h0))
        else $error("flash still drives after select rose");

    c_quad_data: cover property ($rose(io_flash_oe == 4'hF));
    c_dual_data: cover property ($rose(io_flash_oe == 4'h3));
    c_frame: cover property ($fell(cs_n));
endmodule // qwr_link_properties

// [sim/test_quad_io_word_read_wrap_crm.sv]
`include "qwr_defs.svh"
module test_quad_io_word_read_wrap_crm;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [7:0] OPS [4] = '{`QWR_OP_DUAL_IO, `QWR_OP_QUAD_IO,
        `QWR_OP_WORD_QUAD, `QWR_OP_OCTAL_QUAD};
    localparam logic [2:0] DUM [4] = '{3'h0, `QWR_DUMMY_QUAD_IO, `QWR_DUMMY_WORD_QUAD, 3'h0};

    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic quad_io_enable_in = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic execute_in_place;
    logic [2:0] wrap;
    int n_fail = 0;
    int comparisons = 0;

    qwr_if link_if ();
    qwr_host qwr_host_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link_if.host),
        .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata));
    qwr_flash qwr_flash_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link_if.flash),
        .quad_io_enable_in(quad_io_enable_in), .execute_in_place_out(execute_in_place),
        .wrap_setting_out(wrap));
    qwr_link_properties qwr_link_properties_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .sclk(link_if.sclk), .cs_n(link_if.cs_n), .io_host_out(link_if.io_host_out),
        .io_host_oe(link_if.io_host_oe), .io_flash_out(link_if.io_flash_out),
        .io_flash_oe(link_if.io_flash_oe), .io(link_if.io));

    initial begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Samples hready at the rising edge, before the slave's flops move
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) begin
            n++;
            if (n > 100) begin
                n_fail++;
                test_done();
            end
            @(posedge sys_clk_in);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    function automatic logic [31:0] ctl(input logic [7:0] op, input logic send,
            input logic dual, input logic [2:0] dummy, input logic [2:0] cnt);
        return {13'h0, cnt, 1'b0, dummy, 2'h0, dual, send, op};
    endfunction

    // Expected bytes: low address byte, stepping inside a section when sect is set
    function automatic logic [31:0] exp4(input logic [23:0] a, input int sect);
        logic [31:0] r;
        logic [23:0] m;
        r = 32'h0;
        m = 24'(sect - 1);
        for (int i = 0; i < 4; i++) begin
            r = {r[23:0], a[7:0]};
            a = (sect == 0) ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
        end
        return r;
    endfunction

    task automatic frame(input logic [31:0] ctrl, input logic [31:0] field,
            output logic [31:0] rx);
        logic [31:0] q;
        int n;
        bus(1'b1, `QWR_REG_TXWORD, field, q);
        bus(1'b1, `QWR_REG_CTRL, ctrl | 32'h8000_0000, q);
        n = 0;
        q = 32'h0000_0001;
        while (q[0] !== 1'b0) begin
            n++;
            if (n > 400) begin
                n_fail++;
                test_done();
            end
            bus(1'b0, `QWR_REG_STATUS, 32'h0000_0000, q);
        end
        bus(1'b0, `QWR_REG_RXDATA, 32'h0000_0000, rx);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [31:0] q;
        logic [23:0] a;
        repeat (5) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        check(wrap, 3'h1);
        check(execute_in_place, 1'b0);
        frame(ctl(8'h00, 1'b0, 1'b0, 3'h0, 3'h0), 32'hFFFF_FFFF, q);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        check(hresp, 1'b0);
        for (int i = 1; i < 4; i++) begin
            frame(ctl(OPS[i], 1'b1, 1'b0, DUM[i], 3'h4), 32'h0001_2000, q);
            check(q, 32'hFFFF_FFFF);
        end
        quad_io_enable_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = {8'h00, 8'(i + 1), 8'h10};
            frame(ctl(OPS[i], 1'b1, i == 0, DUM[i], 3'h4), {a, 8'hEF}, q);
            check(q, exp4(a, 0));
            check(execute_in_place, 1'b1);
            frame(ctl(8'h00, 1'b0, i == 0, DUM[i], 3'h4), {a + 24'h40, 8'hEF}, q);
            check(q, exp4(a + 24'h40, 0));
            frame(ctl(8'h00, 1'b0, i == 0, 3'h0, 3'h0), 32'hFFFF_FFFF, q);
            check(execute_in_place, 1'b0);
        end
        frame(ctl(OPS[1], 1'b1, 1'b0, DUM[1], 3'h4), 32'h0005_1020, q);
        bus(1'b0, `QWR_REG_CTRL, 32'h0000_0000, q);
        check(q, ctl(OPS[1], 1'b1, 1'b0, DUM[1], 3'h4));
        bus(1'b0, `QWR_REG_TXWORD, 32'h0000_0000, q);
        check(q, 32'h0005_1020);
        frame(ctl(8'h00, 1'b0, 1'b0, DUM[1], 3'h4), 32'h0005_20DF, q);
        check(q, exp4(24'h00_0520, 0));
        check(execute_in_place, 1'b0);
        frame(ctl(OPS[2], 1'b1, 1'b0, DUM[2], 3'h4), 32'h0005_3000, q);
        check(q, exp4(24'h00_0530, 0));
        for (int w = 0; w < 4; w++) begin
            q = {24'h0, 1'b1, 2'(w), 1'b0, 4'hF};
            frame(ctl(`QWR_OP_SET_WRAP, 1'b1, 1'b0, 3'h0, 3'h0), q, q);
            check(wrap, {2'(w), 1'b0});
            a = 24'h00_0700 + 24'(8 << w) - 24'h2;
            frame(ctl(OPS[1 + w % 2], 1'b1, 1'b0, DUM[1 + w % 2], 3'h4), {a, 8'h00}, q);
            check(q, exp4(a, 8 << w));
        end
        frame(ctl(`QWR_OP_SET_WRAP, 1'b1, 1'b0, 3'h0, 3'h0), 32'h0000_0010, q);
        check(wrap, 3'h1);
        frame(ctl(OPS[1], 1'b1, 1'b0, DUM[1], 3'h4), 32'h0007_3E00, q);
        check(q, exp4(24'h00_073E, 0));
        test_done();
    end
endmodule // test_quad_io_word_read_wrap_crm
